// >>> design/lbias_pkg.sv
// Package: register map, reset values, field positions and timing for the display bias bank
package lbias_pkg;
  // Register offsets
  localparam logic [7:0] POS_LEVEL_OFS = 8'h00;
  localparam logic [7:0] NEG_LEVEL_OFS = 8'h01;
  localparam logic [7:0] CTRL_OFS = 8'h03;
  // Values after reset
  localparam logic [7:0] POS_LEVEL_RST = 8'h0a;
  localparam logic [7:0] NEG_LEVEL_RST = 8'h0a;
  localparam logic [7:0] CTRL_RST = 8'h43;
  // Field layout
  localparam int LEVEL_W = 5;
  localparam logic [4:0] LEVEL_MAX = 5'h14;
  localparam logic [7:0] LEVEL_MASK = 8'h1f;
  localparam logic [7:0] CTRL_MASK = 8'h43;
  localparam int POS_DIS_BIT = 1;
  localparam int NEG_DIS_BIT = 0;
  localparam int PROFILE_BIT = 6;
  // Serial link
  localparam logic [6:0] SLAVE_ADDR_DEF = 7'h73;
  localparam int SYNC_W = 5;
  // Timing, times in ns at the system clock rate
  localparam int CLK_PERIOD_NS = 10;
  localparam int SHDN_DELAY_NS = 375000;
  localparam int DISCH_TIME_NS = 20000000;
  localparam int SHDN_CYC = (SHDN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DISCH_CYC = DISCH_TIME_NS / CLK_PERIOD_NS;

  // Settings seen by the analog side
  typedef struct packed {
    logic [4:0] pos_level;
    logic [4:0] neg_level;
    logic positive_discharge_select;
    logic negative_discharge_select;
    logic application_profile_select;
  } lbias_cfg_t;

  // State of one rail
  typedef struct packed {
    logic rail_on;
    logic discharge;
  } lbias_rail_t;
endpackage : lbias_pkg

// >>> design/lbias_rail_seq.sv
// Power-on, shutdown delay and discharge sequencing for one output rail
`timescale 1ns/1ps
module lbias_rail_seq #(
  parameter int SHDN_CYC = lbias_pkg::SHDN_CYC,
  parameter int DISCH_CYC = lbias_pkg::DISCH_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic uvlo,
  input wire logic discharge_en,
  output lbias_pkg::lbias_rail_t rail
);
  localparam int MAXC = (SHDN_CYC > DISCH_CYC) ? SHDN_CYC : DISCH_CYC;
  localparam int CW = $clog2(MAXC + 2);
  localparam logic [CW-1:0] SHDN_LIM = CW'(SHDN_CYC);
  localparam logic [CW-1:0] DISCH_LIM = CW'(DISCH_CYC);

  typedef enum logic [1:0] {
    LBIAS_OFF = 2'b00,
    LBIAS_ON = 2'b01,
    LBIAS_WAIT = 2'b11,
    LBIAS_DISCH = 2'b10
  } lbias_seq_t;

  lbias_seq_t state;
  lbias_seq_t next_state;
  logic [CW-1:0] cnt;
  logic shut;

  // Power off once enable stays low beyond the delay, or at once on lockout
  always_comb begin
    next_state = state;
    shut = 1'b0;
    case (state)
      LBIAS_OFF: begin
        if (enable && !uvlo) next_state = LBIAS_ON;
      end
      LBIAS_ON: begin
        if (uvlo) shut = 1'b1;
        else if (!enable) next_state = LBIAS_WAIT;
      end
      LBIAS_WAIT: begin
        if (uvlo) shut = 1'b1;
        else if (enable) next_state = LBIAS_ON;
        else if (cnt > SHDN_LIM) shut = 1'b1;
      end
      LBIAS_DISCH: begin
        if (cnt >= DISCH_LIM) next_state = LBIAS_OFF;
      end
      default: next_state = LBIAS_OFF;
    endcase
    if (shut) next_state = discharge_en ? LBIAS_DISCH : LBIAS_OFF;
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (!reset_n) state <= LBIAS_OFF;
    else state <= next_state;
  end

  // Cycle counter, loaded with one on every state change
  always_ff @(posedge sys_clk) begin
    if (!reset_n) cnt <= '0;
    else if (next_state != state) cnt <= CW'(1);
    else if (state == LBIAS_WAIT || state == LBIAS_DISCH) cnt <= cnt + CW'(1);
    else cnt <= '0;
  end

  // Registered rail controls
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rail <= '0;
    end else begin
      rail.rail_on <= (next_state == LBIAS_ON) || (next_state == LBIAS_WAIT);
      rail.discharge <= (next_state == LBIAS_DISCH);
    end
  end
endmodule : lbias_rail_seq

// >>> design/lbias_regs.sv
// Display bias configuration bank with serial-link slave and rail sequencing
`timescale 1ns/1ps
module lbias_regs #(
  parameter logic [6:0] SLAVE_ADDR = lbias_pkg::SLAVE_ADDR_DEF,
  parameter int SHDN_CYC = lbias_pkg::SHDN_CYC,
  parameter int DISCH_CYC = lbias_pkg::DISCH_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic pos_enable,
  input wire logic neg_enable,
  input wire logic uvlo,
  output lbias_pkg::lbias_cfg_t cfg,
  output lbias_pkg::lbias_rail_t pos_rail,
  output lbias_pkg::lbias_rail_t neg_rail
);
  typedef enum logic [3:0] {
    LBIAS_IDLE = 4'b0000,
    LBIAS_ADDR = 4'b0001,
    LBIAS_ADDR_ACK = 4'b0011,
    LBIAS_PTR = 4'b0010,
    LBIAS_PTR_ACK = 4'b0110,
    LBIAS_WDAT = 4'b0111,
    LBIAS_WDAT_ACK = 4'b0101,
    LBIAS_RDAT = 4'b0100,
    LBIAS_RDAT_ACK = 4'b1100
  } lbias_bus_t;

  logic [lbias_pkg::SYNC_W-1:0] sync_a;
  logic [lbias_pkg::SYNC_W-1:0] sync_b;
  logic [lbias_pkg::SYNC_W-1:0] pins;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  lbias_bus_t st;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txreg;
  logic [7:0] ptr;
  logic rw;
  logic nack;
  logic wr_en;
  logic [7:0] pos_reg;
  logic [7:0] neg_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] rd_data;
  logic [7:0] next_tx;

  assign pins = {uvlo, neg_enable, pos_enable, sda_in, scl_in};

  // Two-flop synchronisers for every pin input
  genvar gi;
  generate
    for (gi = 0; gi < lbias_pkg::SYNC_W; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          sync_a[gi] <= 1'b1;
          sync_b[gi] <= 1'b1;
        end else begin
          sync_a[gi] <= pins[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  // Delayed copies for edge detection
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= sync_b[0];
      sda_d <= sync_b[1];
    end
  end

  // Line events
  assign scl_rise = sync_b[0] && !scl_d;
  assign scl_fall = !sync_b[0] && scl_d;
  assign start_det = sync_b[0] && scl_d && sda_d && !sync_b[1];
  assign stop_det = sync_b[0] && scl_d && !sda_d && sync_b[1];
  assign wr_en = scl_fall && (st == LBIAS_WDAT) && (bitcnt == 4'h8);

  // Read mux, reserved bits and unmapped offsets read as zero
  always_comb begin
    case (ptr)
      lbias_pkg::POS_LEVEL_OFS: rd_data = pos_reg;
      lbias_pkg::NEG_LEVEL_OFS: rd_data = neg_reg;
      lbias_pkg::CTRL_OFS: rd_data = ctrl_reg;
      default: rd_data = 8'h00;
    endcase
  end

  assign next_tx = {txreg[6:0], 1'b0};

  // Serial slave: address, pointer, write bytes, read bytes
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st <= LBIAS_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      nack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_det) begin
      st <= LBIAS_ADDR;
      bitcnt <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_det) begin
      st <= LBIAS_IDLE;
      sda_oe <= 1'b0;
    end else if (scl_rise) begin
      if (st == LBIAS_ADDR || st == LBIAS_PTR || st == LBIAS_WDAT) begin
        shreg <= {shreg[6:0], sync_b[1]};
        bitcnt <= bitcnt + 4'h1;
      end else if (st == LBIAS_RDAT) begin
        bitcnt <= bitcnt + 4'h1;
      end else if (st == LBIAS_RDAT_ACK) begin
        nack <= sync_b[1];
      end
    end else if (scl_fall) begin
      case (st)
        LBIAS_ADDR: begin
          if (bitcnt == 4'h8) begin
            bitcnt <= 4'h0;
            rw <= shreg[0];
            if (shreg[7:1] == SLAVE_ADDR) begin
              st <= LBIAS_ADDR_ACK;
              sda_oe <= 1'b1;
            end else begin
              st <= LBIAS_IDLE;
            end
          end
        end
        LBIAS_ADDR_ACK: begin
          if (rw) begin
            st <= LBIAS_RDAT;
            txreg <= rd_data;
            sda_oe <= !rd_data[7];
          end else begin
            st <= LBIAS_PTR;
            sda_oe <= 1'b0;
          end
        end
        LBIAS_PTR: begin
          if (bitcnt == 4'h8) begin
            ptr <= shreg;
            bitcnt <= 4'h0;
            st <= LBIAS_PTR_ACK;
            sda_oe <= 1'b1;
          end
        end
        LBIAS_WDAT: begin
          if (bitcnt == 4'h8) begin
            ptr <= ptr + 8'h01;
            bitcnt <= 4'h0;
            st <= LBIAS_WDAT_ACK;
            sda_oe <= 1'b1;
          end
        end
        LBIAS_PTR_ACK, LBIAS_WDAT_ACK: begin
          st <= LBIAS_WDAT;
          sda_oe <= 1'b0;
        end
        LBIAS_RDAT: begin
          if (bitcnt == 4'h8) begin
            ptr <= ptr + 8'h01;
            bitcnt <= 4'h0;
            st <= LBIAS_RDAT_ACK;
            sda_oe <= 1'b0;
          end else begin
            txreg <= next_tx;
            sda_oe <= !next_tx[7];
          end
        end
        LBIAS_RDAT_ACK: begin
          if (nack) begin
            st <= LBIAS_IDLE;
            sda_oe <= 1'b0;
          end else begin
            st <= LBIAS_RDAT;
            txreg <= rd_data;
            sda_oe <= !rd_data[7];
          end
        end
        default: begin
          st <= LBIAS_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain data line only ever pulls low
  always_ff @(posedge sys_clk) begin
    sda_out <= 1'b0;
  end

  // Register bank, reserved bits dropped on write
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pos_reg <= lbias_pkg::POS_LEVEL_RST;
      neg_reg <= lbias_pkg::NEG_LEVEL_RST;
      ctrl_reg <= lbias_pkg::CTRL_RST;
    end else if (wr_en) begin
      case (ptr)
        lbias_pkg::POS_LEVEL_OFS: pos_reg <= shreg & lbias_pkg::LEVEL_MASK;
        lbias_pkg::NEG_LEVEL_OFS: neg_reg <= shreg & lbias_pkg::LEVEL_MASK;
        lbias_pkg::CTRL_OFS: ctrl_reg <= shreg & lbias_pkg::CTRL_MASK;
        default: ctrl_reg <= ctrl_reg;
      endcase
    end
  end

  // Settings to the analog side, codes above the top step held at 6 V
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cfg <= '0;
    end else begin
      cfg.pos_level <= (pos_reg[4:0] > lbias_pkg::LEVEL_MAX) ? lbias_pkg::LEVEL_MAX : pos_reg[4:0];
      cfg.neg_level <= (neg_reg[4:0] > lbias_pkg::LEVEL_MAX) ? lbias_pkg::LEVEL_MAX : neg_reg[4:0];
      cfg.positive_discharge_select <= ctrl_reg[lbias_pkg::POS_DIS_BIT];
      cfg.negative_discharge_select <= ctrl_reg[lbias_pkg::NEG_DIS_BIT];
      cfg.application_profile_select <= ctrl_reg[lbias_pkg::PROFILE_BIT];
    end
  end

  // Per-rail sequencers
  lbias_rail_seq #(
    .SHDN_CYC(SHDN_CYC),
    .DISCH_CYC(DISCH_CYC)
  ) u_pos_seq (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .enable(sync_b[2]),
    .uvlo(sync_b[4]),
    .discharge_en(ctrl_reg[lbias_pkg::POS_DIS_BIT]),
    .rail(pos_rail)
  );

  lbias_rail_seq #(
    .SHDN_CYC(SHDN_CYC),
    .DISCH_CYC(DISCH_CYC)
  ) u_neg_seq (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .enable(sync_b[3]),
    .uvlo(sync_b[4]),
    .discharge_en(ctrl_reg[lbias_pkg::NEG_DIS_BIT]),
    .rail(neg_rail)
  );
endmodule : lbias_regs

// >>> dv/lbias_host.sv
// Serial link host model for the bias bank
`timescale 1ns/1ps
module lbias_host #(
  parameter logic [6:0] ADDR = 7'h73
) (
  input logic sys_clk,
  input logic sda_line,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : w
  // Start or repeated start
  task automatic start();
    sda = 1'b1;
    w(5);
    scl = 1'b1;
    w(10);
    sda = 1'b0;
    w(10);
    scl = 1'b0;
    w(5);
  endtask : start
  task automatic stop();
    sda = 1'b0;
    w(5);
    scl = 1'b1;
    w(10);
    sda = 1'b1;
    w(10);
  endtask : stop
  // Nine bits, line sampled at end of clock high
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      sda = d[i];
      w(5);
      scl = 1'b1;
      w(10);
      q[i] = sda_line;
      scl = 1'b0;
      w(5);
    end
  endtask : xfer
  task automatic wr(input logic [7:0] o, input logic [7:0] d, output logic [2:0] nk);
    logic [8:0] q;
    start();
    xfer({ADDR, 2'b01}, q);
    nk[2] = q[0];
    xfer({o, 1'b1}, q);
    nk[1] = q[0];
    xfer({d, 1'b1}, q);
    nk[0] = q[0];
    stop();
  endtask : wr
  // Address byte alone, acknowledge bit returned
  task automatic probe(input logic [6:0] a, output logic nk);
    logic [8:0] q;
    start();
    xfer({a, 2'b01}, q);
    nk = q[0];
    stop();
  endtask : probe
  // Pointer, repeated start, one byte closed by no-acknowledge
  task automatic rd(input logic [7:0] o, output logic [7:0] v, output logic [2:0] nk);
    logic [8:0] q;
    start();
    xfer({ADDR, 2'b01}, q);
    nk[2] = q[0];
    xfer({o, 1'b1}, q);
    nk[1] = q[0];
    start();
    xfer({ADDR, 2'b11}, q);
    nk[0] = q[0];
    xfer(9'h1ff, q);
    v = q[8:1];
    stop();
  endtask : rd
endmodule : lbias_host

// >>> dv/lbias_regs_checker.sv
// Port checker for the bias bank
`timescale 1ns/1ps
module lbias_regs_checker #(
  parameter int SHDN_CYC = 20,
  parameter int DISCH_CYC = 50
) (
  input logic sys_clk,
  input logic reset_n,
  input logic sda_oe,
  input logic pos_enable,
  input logic uvlo,
  input lbias_pkg::lbias_cfg_t cfg,
  input lbias_pkg::lbias_rail_t pos_rail,
  input lbias_pkg::lbias_rail_t neg_rail
);
  int pcnt;
  int dlen;
  logic [3:0] urec;
  // Enable-low run, discharge run, recent undervoltage
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pcnt <= 0;
      dlen <= 0;
      urec <= 4'h0;
    end else begin
      pcnt <= pos_enable ? 0 : pcnt + 1;
      dlen <= pos_rail.discharge ? dlen + 1 : 0;
      urec <= uvlo ? 4'hf : (urec != 4'h0 ? urec - 4'h1 : 4'h0);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> !sda_oe && cfg == 13'h0)
    else $error("outputs active in reset");
  a_reset_cfg: assert property (disable iff (1'b0) !reset_n ##1 reset_n |=> cfg == 13'h0a57)
    else $error("wrong settings after reset");
  a_level_sat: assert property (cfg.pos_level <= 5'h14 && cfg.neg_level <= 5'h14)
    else $error("level above top code");
  a_uvlo_off: assert property (uvlo [*8] |-> !pos_rail.rail_on && !neg_rail.rail_on)
    else $error("rail on under undervoltage");
  a_shdn_early: assert property ($fell(pos_rail.rail_on) |-> pcnt > SHDN_CYC || urec != 4'h0)
    else $error("rail off too early");
  a_dis_len: assert property ($fell(pos_rail.discharge) |-> dlen == DISCH_CYC)
    else $error("discharge length wrong");
  a_pos_gate: assert property ($rose(pos_rail.discharge) |-> cfg.positive_discharge_select && !pos_rail.rail_on)
    else $error("positive discharge not enabled");
  a_neg_gate: assert property ($rose(neg_rail.discharge) |-> cfg.negative_discharge_select)
    else $error("negative discharge not enabled");
  c_dis: cover property ($fell(pos_rail.discharge));
  c_uvlo: cover property (uvlo && pos_rail.rail_on);
  c_ack: cover property ($rose(sda_oe));
endmodule : lbias_regs_checker
bind lbias_regs lbias_regs_checker #(.SHDN_CYC(SHDN_CYC), .DISCH_CYC(DISCH_CYC)) lbias_regs_checker_i (
  .sys_clk(sys_clk), .reset_n(reset_n), .sda_oe(sda_oe), .pos_enable(pos_enable), .uvlo(uvlo),
  .cfg(cfg), .pos_rail(pos_rail), .neg_rail(neg_rail));

// >>> dv/tb_top.sv
// Self-checking bench for the bias bank
`timescale 1ns/1ps
module tb_top;
  localparam int SHDN = 20;
  localparam int DISCH = 50;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic pos_enable = 1'b0;
  logic neg_enable = 1'b0;
  logic uvlo = 1'b0;
  logic scl, sda, sda_out, sda_oe;
  lbias_pkg::lbias_cfg_t cfg;
  lbias_pkg::lbias_rail_t pos_rail, neg_rail;
  logic [7:0] sh [4];
  int n_fail = 0;
  int cmp_count = 0;
  int seed = 32'h7bd5;
  // Pulled-up open-drain data line
  wire logic sda_line = sda & (sda_out | !sda_oe);
  lbias_regs #(.SHDN_CYC(SHDN), .DISCH_CYC(DISCH)) lbias_regs_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .pos_enable(pos_enable),
    .neg_enable(neg_enable), .uvlo(uvlo), .cfg(cfg), .pos_rail(pos_rail), .neg_rail(neg_rail));
  lbias_host lbias_host_i (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda(sda));
  initial forever #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  function automatic logic [4:0] sat(input logic [7:0] v);
    return v[4:0] > lbias_pkg::LEVEL_MAX ? lbias_pkg::LEVEL_MAX : v[4:0];
  endfunction : sat
  function automatic logic [7:0] mask(input logic [7:0] o);
    return o == lbias_pkg::CTRL_OFS ? lbias_pkg::CTRL_MASK : lbias_pkg::LEVEL_MASK;
  endfunction : mask
  // Write, read back masked, check settings
  task automatic wv(input logic [7:0] o, input logic [7:0] d);
    logic [2:0] nk;
    logic [7:0] v;
    lbias_host_i.wr(o, d, nk);
    chk(nk, 3'b000);
    chk(sda_out, 1'b0);
    sh[o[1:0]] = d;
    lbias_host_i.rd(o, v, nk);
    chk(nk, 3'b000);
    chk(v & mask(o), d & mask(o));
    chk(cfg, {sat(sh[0]), sat(sh[1]), sh[3][1], sh[3][0], sh[3][6]});
  endtask : wv
  // Hang guard
  initial begin
    repeat (100000) @(posedge sys_clk);
    n_fail++;
    print_verdict();
  end
  // Main sequence
  initial begin
    logic [7:0] v;
    logic [2:0] nk;
    logic [31:0] r;
    repeat (6) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (10) @(negedge sys_clk);
    sh = '{8'h0a, 8'h0a, 8'h00, 8'h43};
    for (int i = 0; i < 4; i++) begin
      lbias_host_i.rd(i[7:0], v, nk);
      chk(v & mask(i[7:0]), sh[i] & mask(i[7:0]));
    end
    // Foreign address left unacknowledged
    lbias_host_i.probe(7'h12, nk[0]);
    chk(nk[0], 1'b1);
    wv(8'h00, 8'h14);
    wv(8'h01, 8'hff);
    wv(8'h01, 8'h00);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      wv(8'h03, {r[7], i[2], r[5:2], i[1:0]});
      wv(r[9:8] == 2'h2 ? 8'h03 : {6'h0, r[9:8]}, r[23:16]);
    end
    // Keep profile, positive discharge only
    lbias_host_i.rd(8'h03, v, nk);
    wv(8'h03, (v & 8'hfc) | 8'h02);
    pos_enable = 1'b1;
    neg_enable = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk({pos_rail, neg_rail}, 4'b1010);
    pos_enable = 1'b0;
    neg_enable = 1'b0;
    repeat (SHDN - 2) @(negedge sys_clk);
    chk({pos_rail, neg_rail}, 4'b1010);
    repeat (10) @(negedge sys_clk);
    chk({pos_rail, neg_rail}, 4'b0100);
    repeat (DISCH) @(negedge sys_clk);
    chk({pos_rail, neg_rail}, 4'b0000);
    // Keep profile, negative discharge only
    lbias_host_i.rd(8'h03, v, nk);
    wv(8'h03, (v & 8'hfc) | 8'h01);
    pos_enable = 1'b1;
    neg_enable = 1'b1;
    repeat (10) @(negedge sys_clk);
    uvlo = 1'b1;
    repeat (10) @(negedge sys_clk);
    chk({pos_rail, neg_rail}, 4'b0001);
    uvlo = 1'b0;
    repeat (DISCH + 10) @(negedge sys_clk);
    chk({pos_rail, neg_rail}, 4'b1010);
    print_verdict();
  end
endmodule : tb_top
